// ===== design/dual_port_gpio_with_wakeup.sv
// Two bidirectional I/O ports with pull-high control and port A wake-up.
`timescale 1ns/1ps
// Summary of operation
// - Power-on, low supply or awake watchdog reset sets data and direction.
// - A watchdog reset in sleep or idle leaves all port registers unchanged.
// - Direction one makes a pin a readable input, zero a push-pull output.
// - A data read returns the output latch bit for every pin set as output.
// - Inputs are not latched; a read returns the pin level at the read.
// - The output latch keeps driving the pin until software writes it again.
// - Per-pin pull-high enables act only on inputs and reset to zero.
// - Each port A pin has a wake enable bit, reset to zero.
// - In sleep or idle, a fall on an enabled port A pin wakes the device if it was already enabled and high when sleep began.
// - A pin turned to output before its data bit is written drives high.
// - A bit set or clear reads the whole byte and rewrites all eight bits.
// - Pin n of a port maps to bit n of each of that port's registers.
module dual_port_gpio_with_wakeup
    import gpio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sleepIdleMode,
    input wire logic watchdogSleepReset,
    input wire logic [2:0] regIndex,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    input wire logic [WIDTH-1:0] padAIn,
    output logic [WIDTH-1:0] padAOut,
    output logic [WIDTH-1:0] padAOe,
    output logic [WIDTH-1:0] padAPullHigh,
    input wire logic [WIDTH-1:0] padBIn,
    output logic [WIDTH-1:0] padBOut,
    output logic [WIDTH-1:0] padBOe,
    output logic [WIDTH-1:0] padBPullHigh,
    output logic wakeRequest
);

    // The register file and byte bus are eight bits wide.
    if (WIDTH != 8) begin : gWidthCheck
        $error("dual_port_gpio_with_wakeup supports WIDTH = 8 only");
    end

    // The pin synchronisers below are built with exactly two stages.
    if (SYNC_STAGES != 2) begin : gSyncCheck
        $error("dual_port_gpio_with_wakeup needs two sync stages");
    end

    logic [7:0] aData_reg, aData_next;
    logic [7:0] aDir_reg, aDir_next;
    logic [7:0] aPull_reg, aPull_next;
    logic [7:0] aWake_reg, aWake_next;
    logic [7:0] bData_reg, bData_next;
    logic [7:0] bDir_reg, bDir_next;
    logic [7:0] bPull_reg, bPull_next;
    logic [7:0] readData_reg, readData_next;
    logic [7:0] aMeta_reg, aMeta_next, aSync_reg, aSync_next;
    logic [7:0] bMeta_reg, bMeta_next, bSync_reg, bSync_next;
    logic [7:0] aArmed_reg, aArmed_next;
    logic sleep_reg, sleep_next;
    logic writeOk;
    logic [7:0] aView, bView;

    // A write that coincides with a sleep watchdog reset is dropped so
    // that the reset really leaves every register as it was.
    assign writeOk = regWrite && !watchdogSleepReset;

    // Register writes replace the whole byte; bit set and clear come in
    // as a full byte rewrite from the core.
    always_comb begin
        aData_next = aData_reg;
        aDir_next = aDir_reg;
        aPull_next = aPull_reg;
        aWake_next = aWake_reg;
        bData_next = bData_reg;
        bDir_next = bDir_reg;
        bPull_next = bPull_reg;
        if (writeOk) begin
            if (regIndex == PORT_A_DATA_IDX) begin
                aData_next = regWriteData;
            end else if (regIndex == PORT_A_DIRECTION_IDX) begin
                aDir_next = regWriteData;
            end else if (regIndex == PORT_A_PULLHIGH_ENABLE_IDX) begin
                aPull_next = regWriteData;
            end else if (regIndex == PORT_A_WAKE_ENABLE_IDX) begin
                aWake_next = regWriteData;
            end else if (regIndex == PORT_B_DATA_IDX) begin
                bData_next = regWriteData;
            end else if (regIndex == PORT_B_DIRECTION_IDX) begin
                bDir_next = regWriteData;
            end else if (regIndex == PORT_B_PULLHIGH_ENABLE_IDX) begin
                bPull_next = regWriteData;
            end
        end
    end

    // Only the asynchronous reset restores defaults; the sleep watchdog
    // reset never reaches these flip-flops.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aData_reg <= DATA_RESET;
            aDir_reg <= DIRECTION_RESET;
            aPull_reg <= PULLHIGH_RESET;
            aWake_reg <= WAKE_RESET;
            bData_reg <= DATA_RESET;
            bDir_reg <= DIRECTION_RESET;
            bPull_reg <= PULLHIGH_RESET;
        end else begin
            aData_reg <= aData_next;
            aDir_reg <= aDir_next;
            aPull_reg <= aPull_next;
            aWake_reg <= aWake_next;
            bData_reg <= bData_next;
            bDir_reg <= bDir_next;
            bPull_reg <= bPull_next;
        end
    end

    // Next values of the pin synchronisers; only the second stage feeds
    // any logic, so a metastable first stage never reaches a read.
    always_comb begin
        aMeta_next = padAIn;
        aSync_next = aMeta_reg;
        bMeta_next = padBIn;
        bSync_next = bMeta_reg;
    end

    // Two-stage synchronisers on every pin input.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aMeta_reg <= SYNC_RESET;
            aSync_reg <= SYNC_RESET;
            bMeta_reg <= SYNC_RESET;
            bSync_reg <= SYNC_RESET;
        end else begin
            aMeta_reg <= aMeta_next;
            aSync_reg <= aSync_next;
            bMeta_reg <= bMeta_next;
            bSync_reg <= bSync_next;
        end
    end

    // Per pin read view: the live synchronised level for inputs, the
    // output latch for outputs.
    genvar i;
    for (i = 0; i < 8; i++) begin : gPin
        assign aView[i] = aDir_reg[i] ? aSync_reg[i] : aData_reg[i];
        assign bView[i] = bDir_reg[i] ? bSync_reg[i] : bData_reg[i];
    end

    // The read value is sampled once, on the read strobe, and held; input
    // levels are never latched in between reads.
    always_comb begin
        readData_next = readData_reg;
        if (regRead) begin
            if (regIndex == PORT_A_DATA_IDX) begin
                readData_next = aView;
            end else if (regIndex == PORT_A_DIRECTION_IDX) begin
                readData_next = aDir_reg;
            end else if (regIndex == PORT_A_PULLHIGH_ENABLE_IDX) begin
                readData_next = aPull_reg;
            end else if (regIndex == PORT_A_WAKE_ENABLE_IDX) begin
                readData_next = aWake_reg;
            end else if (regIndex == PORT_B_DATA_IDX) begin
                readData_next = bView;
            end else if (regIndex == PORT_B_DIRECTION_IDX) begin
                readData_next = bDir_reg;
            end else if (regIndex == PORT_B_PULLHIGH_ENABLE_IDX) begin
                readData_next = bPull_reg;
            end else begin
                readData_next = UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            readData_reg <= READ_RESET;
        end else begin
            readData_reg <= readData_next;
        end
    end

    // Arm each enabled port A pin while awake and while it still reads
    // high; the arm freezes once sleep starts, because the clock may stop.
    always_comb begin
        aArmed_next = aArmed_reg;
        sleep_next = sleepIdleMode;
        if (!sleepIdleMode) begin
            aArmed_next = aWake_reg & aSync_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aArmed_reg <= 8'h00;
            sleep_reg <= 1'b0;
        end else begin
            aArmed_reg <= aArmed_next;
            sleep_reg <= sleep_next;
        end
    end

    // The wake path is pure logic from the pads so it works with the
    // clock stopped; an armed pin seen low means it fell from high.
    assign wakeRequest = sleepIdleMode && sleep_reg &&
        |(aArmed_reg & aWake_reg & ~padAIn);

    // Pad drive: latch out, enable when direction is output, weak pull
    // only on inputs.
    assign padAOut = aData_reg;
    assign padAOe = ~aDir_reg;
    assign padAPullHigh = aPull_reg & aDir_reg;
    assign padBOut = bData_reg;
    assign padBOe = ~bDir_reg;
    assign padBPullHigh = bPull_reg & bDir_reg;
    assign regReadData = readData_reg;

endmodule

// ===== design/gpio_pkg.sv
// Shared constants for the dual port general purpose I/O block.
package gpio_pkg;
    // Register indices on the core register port.
    localparam logic [2:0] PORT_A_DATA_IDX = 3'h0;
    localparam logic [2:0] PORT_A_DIRECTION_IDX = 3'h1;
    localparam logic [2:0] PORT_A_PULLHIGH_ENABLE_IDX = 3'h2;
    localparam logic [2:0] PORT_A_WAKE_ENABLE_IDX = 3'h3;
    localparam logic [2:0] PORT_B_DATA_IDX = 3'h4;
    localparam logic [2:0] PORT_B_DIRECTION_IDX = 3'h5;
    localparam logic [2:0] PORT_B_PULLHIGH_ENABLE_IDX = 3'h6;
    // Reset values: data and direction high, enables low.
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam logic [7:0] DIRECTION_RESET = 8'hFF;
    localparam logic [7:0] PULLHIGH_RESET = 8'h00;
    localparam logic [7:0] WAKE_RESET = 8'h00;
    // Value returned for an index with no register behind it.
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // Reset values of the read buffer and the pin synchronisers.
    localparam logic [7:0] READ_RESET = 8'h00;
    localparam logic [7:0] SYNC_RESET = 8'h00;
    // Number of flip-flops in each pin input synchroniser.
    localparam int SYNC_STAGES = 2;
endpackage

// ===== sim/dual_port_gpio_with_wakeup_assertions.sv
// Concurrent checks on the register and port A pins of the I/O block.
`timescale 1ns/1ps
module dual_port_gpio_with_wakeup_assertions (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sleepIdleMode,
    input wire logic watchdogSleepReset,
    input wire logic regWrite,
    input wire logic wakeRequest,
    input wire logic [2:0] regIndex,
    input wire logic [7:0] regWriteData,
    input wire logic [7:0] padAIn,
    input wire logic [7:0] padAOut,
    input wire logic [7:0] padAOe,
    input wire logic [7:0] padAPullHigh
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // A write only lands while the watchdog hold is low.
    wire wrOk = regWrite && !watchdogSleepReset;
    chk_data_write: assert property (wrOk && regIndex == 3'h0 |=>
        padAOut == $past(regWriteData)) else $error("latch not loaded");
    chk_data_hold: assert property (!(regWrite && regIndex == 3'h0) |=>
        $stable(padAOut)) else $error("latch moved without a write");
    chk_dir_write: assert property (wrOk && regIndex == 3'h1 |=>
        padAOe == ~$past(regWriteData)) else $error("drive enable wrong");
    chk_pull_write: assert property (wrOk && regIndex == 3'h2 |=>
        padAPullHigh == ($past(regWriteData) & ~padAOe)) else $error("pull");
    chk_pull_gate: assert property (
        (padAPullHigh & padAOe) == 8'h00) else $error("pull on output");
    chk_wdt_keep: assert property (watchdogSleepReset |=>
        $stable(padAOe) && $stable(padAPullHigh)) else $error("reg changed");
    chk_reset_vals: assert property ($rose(rstn) |-> padAOut == 8'hFF &&
        padAOe == 8'h00 && padAPullHigh == 8'h00) else $error("reset value");
    chk_wake_awake: assert property (
        !sleepIdleMode |-> !wakeRequest) else $error("wake while awake");
    // A standing wake request, with no write that could retune the
    // enables, must stay up while sleep and the pins are held.
    sequence wakeSeen;
        wakeRequest && !regWrite;
    endsequence
    sequence wakeKept;
        sleepIdleMode && $stable(padAIn);
    endsequence
    chk_wake_hold: assert property (
        wakeSeen ##1 wakeKept |-> wakeRequest) else $error("wake dropped");
    chk_wake_pin_low: assert property (
        wakeRequest |-> padAIn != 8'hFF) else $error("wake with pins high");
endmodule
bind dual_port_gpio_with_wakeup
    dual_port_gpio_with_wakeup_assertions chk_u (.*);

// ===== sim/gpio_board_model.sv
// Board side of both ports: switch drive, weak pull-ups and open pins.
`timescale 1ns/1ps
module gpio_board_model (
    input wire logic [7:0] padAOut,
    input wire logic [7:0] padAOe,
    input wire logic [7:0] padAPullHigh,
    input wire logic [7:0] extA,
    input wire logic [7:0] padBOut,
    input wire logic [7:0] padBOe,
    input wire logic [7:0] padBPullHigh,
    input wire logic [7:0] extB,
    input wire logic extOn,
    output logic [7:0] padAIn,
    output logic [7:0] padBIn
);
    // An open unpulled pin shows the inverse latch, so stale data never fits.
    assign padAIn = padAOe & padAOut | ~padAOe &
        (extOn ? extA : padAPullHigh | ~padAOut);
    assign padBIn = padBOe & padBOut | ~padBOe &
        (extOn ? extB : padBPullHigh | ~padBOut);
endmodule

// ===== sim/tb_dual_port_gpio_with_wakeup.sv
// Register-level testbench for the dual port I/O block.
`timescale 1ns/1ps
module tb_dual_port_gpio_with_wakeup;
    logic sys_clk = 0, rstn = 0, sleepIdleMode = 0, watchdogSleepReset = 0;
    logic regWrite = 0, regRead = 0, extOn = 1, wakeRequest;
    logic [2:0] regIndex = 3'h0;
    logic [7:0] regWriteData = 8'h00, extA = 8'hFF, extB = 8'h3C, v;
    logic [7:0] regReadData, padAIn, padAOut, padAOe, padAPullHigh, padBIn;
    logic [7:0] padBOut, padBOe, padBPullHigh;
    int num_errors = 0, n_compared = 0;
    // Free running 200 MHz clock.
    always #2.5 sys_clk = ~sys_clk;
    // Design and board model meet on the pad signals by name.
    dual_port_gpio_with_wakeup dut_u (.*);
    gpio_board_model board_u (.*);
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        num_errors += int'(g !== e);
        if (g !== e) $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    endtask
    task acc(input logic w, input logic [2:0] i, input logic [7:0] d);
        @(negedge sys_clk);
        regIndex = i;
        regWriteData = d;
        regWrite = w;
        regRead = !w;
        @(negedge sys_clk);
        {regWrite, regRead} = 2'b00;
        v = regReadData;
        if (!w) chk(v, d);
    endtask
    task report_and_stop;
        $display("errors %0d of %0d checks", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // A hang is cut short far beyond the fewer than 80 cycles the run needs.
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        report_and_stop;
    end
    // Reset, then scenarios; port B pins read 3C until driven.
    initial begin
        repeat (16) @(negedge sys_clk);
        rstn = 1;
        chk(padAOut & padBOut, 8'hFF);
        // Synchronisers start from zero, so let the pins settle first.
        repeat (2) @(negedge sys_clk);
        acc(0, 3'h0, 8'hFF);
        for (int i = 1; i < 8; i++)
            acc(0, i[2:0], i == 4 ? 8'h3C : {8{i[1:0] == 2'b01}});
        acc(1, 3'h5, 8'h0F);
        acc(1, 3'h4, 8'hA5);
        acc(0, 3'h4, 8'hAC);
        // Input pins change level; the next read must follow them.
        extB = 8'h35;
        @(negedge sys_clk);
        acc(0, 3'h4, 8'hA5);
        acc(0, 3'h5, 8'h0F);
        acc(1, 3'h5, v | 8'h80);
        chk(padBOe, 8'h70);
        // Undriven inputs show the weak pull-high or, without it, no fit.
        acc(1, 3'h6, 8'hFF);
        chk(padBPullHigh, 8'h8F);
        extOn = 0;
        @(negedge sys_clk);
        acc(0, 3'h4, 8'hAF);
        acc(1, 3'h6, 8'h00);
        @(negedge sys_clk);
        acc(0, 3'h4, 8'h2A);
        extOn = 1;
        acc(1, 3'h3, 8'h01);
        // The arm needs pin 0 seen high through the synchroniser first.
        repeat (2) @(negedge sys_clk);
        sleepIdleMode = 1;
        repeat (2) @(negedge sys_clk);
        extA = 8'hFD;
        #1 chk(wakeRequest, 8'h00);
        @(negedge sys_clk);
        extA = 8'hFC;
        #1 chk(wakeRequest, 8'h01);
        acc(1, 3'h1, 8'h00);
        chk(padAOut & padAOe, 8'hFF);
        acc(1, 3'h2, 8'h81);
        chk(padAPullHigh, 8'h00);
        watchdogSleepReset = 1;
        acc(1, 3'h4, 8'h00);
        chk(padBOut, 8'hA5);
        // A second full reset in mid-run restores every default.
        sleepIdleMode = 0;
        watchdogSleepReset = 0;
        rstn = 0;
        repeat (2) @(negedge sys_clk);
        rstn = 1;
        chk(padAOut & padBOut, 8'hFF);
        chk(padAOe | padBOe, 8'h00);
        acc(0, 3'h3, 8'h00);
        acc(0, 3'h2, 8'h00);
        report_and_stop;
    end
endmodule
